// File: pkg/asp_pkg.sv
// Purpose: Shared constants for the converter serial result port
// Assumes: 16-bit conversion result, 50 MHz system clock
// Notes: Clock divider figures are plain defaults; the true rates are set per design
package asp_pkg;
	localparam int RES_W = 16;
	localparam int BIT_CNT_W = 5;
	localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h0f;
	localparam int PIN_BIT_FIVE = 5;
	localparam int PIN_BIT_SIX = 6;
	localparam int PIN_BIT_SEVEN = 7;
	localparam int HALF_AFTER_DEF = 2;
	localparam int HALF_DURING_DEF = 1;
	localparam int DIV_W = 8;
	localparam int SYNC_W = 9;
	localparam logic [RES_W-1:0] RES_RST = 16'h0000;
	// Synchroniser vector layout
	localparam int S_SERPAR = 0;
	localparam int S_CLKSRC = 1;
	localparam int S_FMT = 2;
	localparam int S_P5 = 3;
	localparam int S_P6 = 4;
	localparam int S_P7 = 5;
	localparam int S_SCLK = 6;
	localparam int S_CSN = 7;
	localparam int S_SPARE = 8;
	typedef enum logic [1:0] {ASP_IDLE, ASP_MASTER, ASP_SLAVE} asp_state_t;
endpackage : asp_pkg

// File: pkg/asp_shift_if.sv
// Purpose: Link between port control and the output shift path
// Assumes: One clock domain
// Notes: Width follows the result width
`timescale 1ns/1ns
`default_nettype none
interface asp_shift_if #(parameter int W = 16);
	logic load;
	logic shift;
	logic tail;
	logic [W-1:0] data;
	logic msb;
	modport ctrl(output load, output shift, output tail, output data, input msb);
	modport sreg(input load, input shift, input tail, input data, output msb);
endinterface : asp_shift_if
`default_nettype wire

// File: rtl/asp_shifter.sv
// Purpose: Output shift path, most significant bit first
// Assumes: Load and shift never in the same cycle; load wins if they are
// Notes: Tail bit enters at bit 0 so chained data trails the own result
`timescale 1ns/1ns
`default_nettype none
module asp_shifter #(parameter int W = 16) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	asp_shift_if.sreg sh
);
	logic [W-1:0] sr_r;
	// ==========================================
	// Shift register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			sr_r <= '0;
		end else if (sh.load) begin
			sr_r <= sh.data;
		end else if (sh.shift) begin
			sr_r <= {sr_r[W-2:0], sh.tail};
		end
	end
	assign sh.msb = sr_r[W-1];
endmodule : asp_shifter
`default_nettype wire

// File: rtl/asp_serial_port.sv
// Purpose: Result output port of the converter with serial option pins
// Assumes: Conversion start and done strobes come from the core on i_sys_clk
// Notes: External serial clock is oversampled; it must stay well below i_sys_clk/4
// ==========================================
`timescale 1ns/1ns
`default_nettype none
module asp_serial_port
	import asp_pkg::*;
#(
	parameter int HALF_AFTER = asp_pkg::HALF_AFTER_DEF,
	parameter int HALF_DURING = asp_pkg::HALF_DURING_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_serial_parallel_select,
	input wire logic i_clock_source_select,
	input wire logic i_binary_format_select,
	input wire logic i_conv_start,
	input wire logic i_conv_done,
	input wire logic [asp_pkg::RES_W-1:0] i_conv_result,
	input wire logic i_parallel_bit_five,
	output logic o_parallel_bit_five,
	output logic o_parallel_bit_five_oe,
	input wire logic i_parallel_bit_six,
	output logic o_parallel_bit_six,
	output logic o_parallel_bit_six_oe,
	input wire logic i_parallel_bit_seven,
	output logic o_parallel_bit_seven,
	output logic o_parallel_bit_seven_oe,
	input wire logic i_serial_clock,
	output logic o_serial_clock,
	output logic o_serial_clock_oe,
	input wire logic i_chip_select_n,
	output logic o_frame_sync,
	output logic o_serial_result_out
);
	import asp_pkg::*;

	// ==========================================
	// Functions
	function automatic logic [RES_W-1:0] fmt_result(input logic [RES_W-1:0] r, input logic ob);
		fmt_result = {r[RES_W-1] ^ ~ob, r[RES_W-2:0]};
	endfunction : fmt_result

	// ==========================================
	// Pin synchronisers
	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;
	logic sclk_d_r;
	logic csn_d_r;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			meta_r <= SYNC_W'(1) << S_CSN;
			sync_r <= SYNC_W'(1) << S_CSN;
			sclk_d_r <= 1'b0;
			csn_d_r <= 1'b1;
		end else begin
			meta_r <= {1'b0, i_chip_select_n, i_serial_clock, i_parallel_bit_seven,
				i_parallel_bit_six, i_parallel_bit_five, i_binary_format_select,
				i_clock_source_select, i_serial_parallel_select};
			sync_r <= meta_r;
			sclk_d_r <= sync_r[S_SCLK];
			csn_d_r <= sync_r[S_CSN];
		end
	end

	logic ser_mode;
	logic slave_mode;
	logic sync_pol;
	logic clk_inv;
	logic rdc_sel;
	logic chain_in;
	logic ob_sel;
	assign ser_mode = sync_r[S_SERPAR];
	assign slave_mode = sync_r[S_CLKSRC];
	assign ob_sel = sync_r[S_FMT];
	assign sync_pol = sync_r[S_P5];
	assign clk_inv = sync_r[S_P6];
	assign rdc_sel = sync_r[S_P7];
	assign chain_in = sync_r[S_P7];

	// Data update edge of the external clock swaps with the invert pin
	logic ext_rise;
	logic ext_fall;
	logic upd_edge;
	logic smp_edge;
	assign ext_rise = sync_r[S_SCLK] & ~sclk_d_r;
	assign ext_fall = ~sync_r[S_SCLK] & sclk_d_r;
	assign upd_edge = clk_inv ? ext_fall : ext_rise;
	assign smp_edge = clk_inv ? ext_rise : ext_fall;
	logic csn_fall;
	assign csn_fall = ~sync_r[S_CSN] & csn_d_r;

	// ==========================================
	// Result storage
	logic [RES_W-1:0] res_r;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			res_r <= RES_RST;
		end else if (i_conv_done) begin
			res_r <= i_conv_result;
		end
	end

	// ==========================================
	// Read sequencing
	asp_state_t state_r;
	logic [BIT_CNT_W-1:0] bit_cnt_r;
	logic [DIV_W-1:0] div_cnt_r;
	logic [DIV_W-1:0] half_r;
	logic phase_r;
	logic chain_r;
	logic m_start;
	logic half_done;
	// Read after convert waits for done; read during convert starts with the new conversion
	assign m_start = ser_mode && !slave_mode && ((rdc_sel && i_conv_start)
		|| (!rdc_sel && i_conv_done));
	assign half_done = (div_cnt_r == half_r);

	asp_shift_if #(.W(RES_W)) sh ();
	asp_shifter #(.W(RES_W)) u_shifter (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.sh(sh)
	);

	always_comb begin
		sh.load = 1'b0;
		sh.data = fmt_result(res_r, ob_sel);
		sh.tail = chain_r;
		sh.shift = 1'b0;
		if (state_r == ASP_IDLE) begin
			sh.load = m_start || (ser_mode && slave_mode && csn_fall);
			if (!rdc_sel && i_conv_done) begin
				sh.data = fmt_result(i_conv_result, ob_sel);
			end
		end else if (state_r == ASP_MASTER) begin
			sh.shift = half_done && phase_r;
		end else begin
			sh.shift = upd_edge;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			state_r <= ASP_IDLE;
		end else begin
			unique case (state_r)
				ASP_IDLE: begin
					if (m_start) begin
						state_r <= ASP_MASTER;
					end else if (ser_mode && slave_mode && csn_fall) begin
						state_r <= ASP_SLAVE;
					end
				end
				ASP_MASTER: begin
					if (half_done && phase_r && bit_cnt_r == LAST_BIT) begin
						state_r <= ASP_IDLE;
					end
				end
				ASP_SLAVE: begin
					if (sync_r[S_CSN] || !ser_mode) begin
						state_r <= ASP_IDLE;
					end
				end
			endcase
		end
	end

	// Master clock divider and bit counter
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			div_cnt_r <= '0;
			phase_r <= 1'b0;
			bit_cnt_r <= '0;
			half_r <= DIV_W'(HALF_AFTER - 1);
		end else if (state_r == ASP_IDLE) begin
			div_cnt_r <= '0;
			phase_r <= 1'b0;
			bit_cnt_r <= '0;
			half_r <= rdc_sel ? DIV_W'(HALF_DURING - 1) : DIV_W'(HALF_AFTER - 1);
		end else if (state_r == ASP_MASTER) begin
			if (half_done) begin
				div_cnt_r <= '0;
				phase_r <= ~phase_r;
				if (phase_r) begin
					bit_cnt_r <= bit_cnt_r + 1'b1;
				end
			end else begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end

	// Chain bit sampled on the edge opposite to the update edge
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			chain_r <= 1'b0;
		end else if (state_r == ASP_SLAVE && smp_edge) begin
			chain_r <= chain_in;
		end
	end

	// ==========================================
	// Serial pins
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_serial_clock <= 1'b0;
			o_serial_clock_oe <= 1'b0;
			o_frame_sync <= 1'b0;
		end else begin
			o_serial_clock_oe <= ser_mode && !slave_mode;
			o_serial_clock <= (state_r == ASP_MASTER && (phase_r ^ half_done)) ^ clk_inv;
			o_frame_sync <= (state_r == ASP_MASTER) ^ sync_pol;
		end
	end
	assign o_serial_result_out = sh.msb;

	// ==========================================
	// Shared data pins
	logic [RES_W-1:0] par_word;
	assign par_word = fmt_result(res_r, ob_sel);
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_parallel_bit_five <= 1'b0;
			o_parallel_bit_six <= 1'b0;
			o_parallel_bit_seven <= 1'b0;
			o_parallel_bit_five_oe <= 1'b0;
			o_parallel_bit_six_oe <= 1'b0;
			o_parallel_bit_seven_oe <= 1'b0;
		end else begin
			o_parallel_bit_five <= par_word[PIN_BIT_FIVE];
			o_parallel_bit_six <= par_word[PIN_BIT_SIX];
			o_parallel_bit_seven <= par_word[PIN_BIT_SEVEN];
			o_parallel_bit_five_oe <= !ser_mode;
			o_parallel_bit_six_oe <= !ser_mode;
			o_parallel_bit_seven_oe <= !ser_mode;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_master_go;
		state_r == ASP_IDLE && m_start;
	endsequence
	sequence s_master_end;
		state_r == ASP_MASTER && half_done && phase_r && bit_cnt_r == LAST_BIT;
	endsequence

	chk_par_pins_drive: assert property (!ser_mode |=> o_parallel_bit_six_oe
		&& o_parallel_bit_six == $past(par_word[PIN_BIT_SIX]))
		else $error("parallel bit six not driven");
	chk_sync_polarity: assert property (state_r == ASP_MASTER |=> o_frame_sync ==
		!$past(sync_pol)) else $error("frame sync level wrong");
	chk_sclk_idle_inv: assert property (state_r == ASP_IDLE |=> o_serial_clock
		== $past(clk_inv)) else $error("idle serial clock level wrong");
	chk_rdc_start: assert property (s_master_go |-> (rdc_sel ? i_conv_start
		: i_conv_done)) else $error("master read started on wrong event");
	chk_during_period: assert property (state_r == ASP_IDLE && rdc_sel |=>
		half_r == DIV_W'(HALF_DURING - 1)) else $error("read-during period wrong");
	chk_after_wait: assert property (state_r == ASP_IDLE && ser_mode && !slave_mode
		&& !rdc_sel && !i_conv_done |=> state_r == ASP_IDLE)
		else $error("read-after started before done");
	chk_slave_chain: assert property (state_r == ASP_SLAVE && upd_edge |-> sh.shift
		&& sh.tail == chain_r) else $error("chain bit not shifted in");
	chk_master_clk_oe: assert property (ser_mode && !slave_mode |=> o_serial_clock_oe)
		else $error("master clock not driven");
	chk_sync_frame: assert property (s_master_go |=> (state_r == ASP_MASTER)[*2])
		else $error("frame did not open");
	chk_sync_close: assert property (s_master_end |=> state_r == ASP_IDLE ##1
		o_frame_sync == $past(sync_pol)) else $error("frame sync not released");
	chk_msb_first: assert property (sh.load |=> o_serial_result_out ==
		$past(sh.data[RES_W-1])) else $error("first bit not MSB");
	chk_tail_capture: assert property (state_r == ASP_SLAVE && smp_edge |=>
		chain_r == $past(chain_in)) else $error("chain bit not captured");
endmodule : asp_serial_port
`default_nettype wire

// File: verification/asp_host_model.sv
// Purpose: Host model that clocks slave reads and feeds chain data
// Assumes: Behavioural timing, serial clock half period HALF ns
// Notes: Clock parks at the update level so the first edge samples
`timescale 1ns/1ns
`default_nettype none
module asp_host_model #(parameter int HALF = 80) (
	input wire logic i_inv,
	input wire logic i_sdo,
	output logic o_sclk,
	output logic o_csn,
	output logic o_chain
);
	logic busy = 1'b0;
	logic clk_r = 1'b0;
	logic bit_r = 1'b0;
	logic idle_r = 1'b0;
	// Idle chain line keeps toggling so a stale level is never taken for data
	always #HALF idle_r = ~idle_r;
	assign o_sclk = busy ? clk_r : ~i_inv;
	assign o_chain = busy ? bit_r : idle_r;
	assign o_csn = ~busy;
	task automatic read_frame(input logic [7:0] ch, output logic [23:0] got);
		got = '0;
		bit_r = ch[7];
		clk_r = ~i_inv;
		busy = 1'b1;
		#(3*HALF);
		for (int n = 0; n < 24; n++) begin
			clk_r = i_inv;
			got = {got[22:0], i_sdo};
			#HALF;
			clk_r = ~i_inv;
			bit_r = (n < 7) ? ch[6-n] : ~bit_r;
			#HALF;
		end
		busy = 1'b0;
	endtask : read_frame
endmodule : asp_host_model
`default_nettype wire

// File: verification/tb_asp_serial_port.sv
// Purpose: Self-checking bench for the serial result port
// Assumes: Option pins settle within six cycles
// Notes: Short half periods keep master reads brief
`timescale 1ns/1ns
`default_nettype none
module tb_asp_serial_port;
	import asp_pkg::*;
	localparam int HA = 2;
	localparam int HD = 1;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ser = 1'b0, src = 1'b0, fmt = 1'b1, pol = 1'b0, inv = 1'b0, read_during_convert_select = 1'b0;
	logic start = 1'b0, done = 1'b0;
	logic [RES_W-1:0] res = '0;
	logic [7:0] ch;
	logic [23:0] got;
	logic p5o, p5e, p6o, p6e, p7o, p7e, sco, sce, fs, sdo, hclk, hcsn, hch;
	wire p5, p6, p7, sclk;
	int fails = 0, checked = 0;
	// ==========================================
	// Pin resolution
	assign p5 = p5e ? p5o : pol;
	assign p6 = p6e ? p6o : inv;
	assign p7 = p7e ? p7o : (src ? hch : read_during_convert_select);
	assign sclk = sce ? sco : hclk;
	asp_serial_port #(.HALF_AFTER(HA), .HALF_DURING(HD)) DUT (.i_sys_clk(clk), .i_rstn(rstn),
		.i_serial_parallel_select(ser), .i_clock_source_select(src),
		.i_binary_format_select(fmt), .i_conv_start(start), .i_conv_done(done),
		.i_conv_result(res), .i_parallel_bit_five(p5), .o_parallel_bit_five(p5o),
		.o_parallel_bit_five_oe(p5e), .i_parallel_bit_six(p6), .o_parallel_bit_six(p6o),
		.o_parallel_bit_six_oe(p6e), .i_parallel_bit_seven(p7), .o_parallel_bit_seven(p7o),
		.o_parallel_bit_seven_oe(p7e), .i_serial_clock(sclk), .o_serial_clock(sco),
		.o_serial_clock_oe(sce), .i_chip_select_n(hcsn), .o_frame_sync(fs),
		.o_serial_result_out(sdo));
	asp_host_model host (.i_inv(inv), .i_sdo(sdo), .o_sclk(hclk), .o_csn(hcsn), .o_chain(hch));
	initial forever #10 clk = ~clk;
	// ==========================================
	// Helpers
	function automatic logic [15:0] fmtd(input logic [15:0] r, input logic f);
		return f ? r : {~r[15], r[14:0]};
	endfunction : fmtd
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results;
		$display("fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task automatic pulse(input logic st);
		if (st) start = 1'b1;
		else done = 1'b1;
		step(1);
		start = 1'b0;
		done = 1'b0;
	endtask : pulse
	// Master read; read-after draws its own word, read-during sends w
	task automatic mread(input logic dur, input logic [15:0] w);
		int h;
		h = dur ? HD : HA;
		chk("fs_idle", fs, pol);
		chk("sclk_idle", sco, inv);
		if (!dur) begin
			pulse(1'b1);
			step(4);
			chk("fs_held", fs, pol);
			res = 16'($urandom);
			w = fmtd(res, fmt);
		end
		pulse(dur);
		step(h);
		for (int k = 0; k < 16; k++) begin
			chk("sdo", sdo, w[15-k]);
			chk("fs_act", fs, !pol);
			chk("sclk_run", sco, !inv);
			step(2 * h);
		end
		step(4);
		chk("fs_end", fs, pol);
	endtask : mread
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'hb885));
		repeat (12) @(posedge clk);
		#2;
		rstn = 1'b1;
		for (int i = 0; i < 4; i++) begin
			fmt = 1'($urandom);
			res = 16'($urandom);
			step(6);
			pulse(1'b0);
			step(4);
			chk("par", {p7e, p6e, p5e, p7o, p6o, p5o}, {3'h7, res[7:5]});
		end
		ser = 1'b1;
		for (int i = 0; i < 4; i++) begin
			pol = 1'($urandom);
			inv = 1'($urandom);
			fmt = 1'($urandom);
			step(6);
			chk("sclk_oe", sce, 1'b1);
			chk("par_oe_off", {p7e, p6e, p5e}, 3'h0);
			mread(1'b0, res);
		end
		read_during_convert_select = 1'b1;
		for (int i = 0; i < 3; i++) begin
			step(6);
			mread(1'b1, fmtd(res, fmt));
			res = 16'($urandom);
			pulse(1'b0);
		end
		src = 1'b1;
		for (int i = 0; i < 4; i++) begin
			inv = i[0];
			fmt = i[1];
			res = 16'($urandom);
			ch = 8'($urandom);
			step(6);
			pulse(1'b0);
			step(2);
			chk("sclk_oe", sce, 1'b0);
			host.read_frame(ch, got);
			step(6);
			chk("chain", got, {fmtd(res, fmt), ch});
		end
		results();
	end
	// Watchdog: the whole sequence needs about 1400 cycles
	initial begin
		#400000;
		fails++;
		results();
	end
endmodule : tb_asp_serial_port
`default_nettype wire
